// *** src/tmr_pkg.sv ***
/*
 * Shared constants and helper functions for the 8-bit reloading timer,
 * its rate prescaler and its event-input front end.
 * Assumes a single clock domain; callers import the whole package.
 */
package tmr_pkg;

    // ------------------------------------------------------------------
    // counter geometry
    // ------------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam int PRE_W = 8;
    localparam int RATE_W = 3;

    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] RELOAD_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // overflow boundary masks: 256, 64, 32 and 16 counts
    localparam logic [CNT_W-1:0] MASK_256 = 8'hff;
    localparam logic [CNT_W-1:0] MASK_64 = 8'h3f;
    localparam logic [CNT_W-1:0] MASK_32 = 8'h1f;
    localparam logic [CNT_W-1:0] MASK_16 = 8'h0f;

    // ------------------------------------------------------------------
    // prescaler shifts: slow source divides by 2..256, fast by 1..128
    // ------------------------------------------------------------------
    localparam logic [3:0] SLOW_SHIFT_TOP = 4'h8;
    localparam logic [3:0] FAST_SHIFT_TOP = 4'h7;

    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // boundary mask chosen by the auto-load and buzzer bits in pwm mode
    function automatic logic [CNT_W-1:0] boundary_mask(
        input logic pwm,
        input logic aload,
        input logic buzz
    );
        logic [CNT_W-1:0] m;
        m = MASK_256;
        if (pwm) begin
            case ({aload, buzz})
                2'b00: m = MASK_256;
                2'b01: m = MASK_64;
                2'b10: m = MASK_32;
                2'b11: m = MASK_16;
                default: m = MASK_256;
            endcase
        end
        return m;
    endfunction

    // low-bit mask of a given width, width 0 gives no bits
    function automatic logic [PRE_W-1:0] low_mask(input logic [3:0] shift);
        logic [PRE_W-1:0] m;
        m = PRE_RST;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < int'(shift)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

endpackage

// *** src/event_front.sv ***
/*
 * Event input front end: two-stage synchroniser and falling-edge pulse.
 * Assumes the event pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module event_front
    import tmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic pin_i,
    output logic fall_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } front_t;

    front_t st_ff;
    front_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.prev = st_ff.s2;
    end

    // only the second stage and its delayed copy are inspected
    assign fall_o = ce_i & st_ff.prev & ~st_ff.s2; // [R24] [R2]

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_ff <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1};
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// *** src/rate_prescaler.sv ***
/*
 * Rate prescaler: produces one-cycle count ticks from the slow cpu
 * strobe or from the fast clock, divided by a power of two.
 * Assumes cpu_tick_i is a one-cycle strobe synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module rate_prescaler
    import tmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic fast_i,
    input wire logic cpu_tick_i,
    input wire logic [RATE_W-1:0] rate_i,
    output logic tick_o
);

    typedef struct packed {
        logic [PRE_W-1:0] div;
    } pre_t;

    pre_t st_ff;
    pre_t nxt_st;
    logic base;
    logic [3:0] shift;
    logic [PRE_W-1:0] m;

    always_comb begin
        base = fast_i | cpu_tick_i;
        shift = fast_i ? (FAST_SHIFT_TOP - {1'b0, rate_i})
                       : (SLOW_SHIFT_TOP - {1'b0, rate_i}); // [R23]
        m = low_mask(shift);
        tick_o = ce_i & run_i & base & ((st_ff.div & m) == m);
        nxt_st = st_ff;
        if (!run_i) begin
            nxt_st.div = PRE_RST;
        end else if (base) begin
            nxt_st.div = st_ff.div + PRE_ONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_ff <= '{div: PRE_RST};
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// *** src/timer_event_counter_buzzer_pwm.sv ***
/*
 * 8-bit reloading timer/counter with event counting, buzzer square wave
 * and four-resolution pwm, sharing one output pin with general I/O.
 * Assumes all control inputs are synchronous to clk_i, that clk_i is the
 * fast oscillator and cpu_tick_i marks each slow cpu clock.
 */
// Notes on behaviour
// R1 - event clock select routes counting to falling edges of the event pin
// R2 - each event falling edge adds exactly one to the counter
// R3 - overflow event raised when the counter wraps from ff to 00
// R4 - event pin wake-up suppressed while event counting is selected
// R5 - event pin interrupt disabled and its flag held zero while event counting
// R6 - buzzer level toggles on every overflow, half the overflow rate
// R7 - buzzer enable hands the shared pin to the buzzer; clear restores gpio
// R8 - overflow flag still set with outputs active; interrupt when enabled
// R9 - software keeps pwm enable low while the buzzer is enabled
// R10 - pwm drives the pin only with timer running and pwm enable set
// R11 - pwm period starts high, falls when counter equals duty
// R12 - overflow ends the pwm period and drives the output high again
// R13 - software clears the counter before starting pwm
// R14 - a new pwm value takes effect only at the next period
// R15 - in pwm, auto-load and buzzer bits pick 256, 64, 32 or 16 counts
// R16 - in pwm the overflow interrupt period equals the pwm period
// R17 - pwm enable hands the shared pin to pwm; clear restores gpio
// R18 - output enable gates the carrier while the counter keeps counting
// R19 - software loads counter and reload alike before enabling
// R20 - prescale source select ignored while the event clock is selected
// R21 - every overflow reloads the counter from the reload value; in pwm mode the code clears it to 00 instead
// R22 - reload writes go to a shadow copied in at the next overflow
// R23 - internal source: cpu clock /2..256 when 0, fast clock /1..128 when 1
// R24 - event input passes a two-stage synchroniser before edge detection
`timescale 1ns/1ps
`default_nettype none

module timer_event_counter_buzzer_pwm
    import tmr_pkg::*;
#(
    parameter int COUNT_WIDTH = CNT_W
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic cpu_tick_i,
    input wire logic timer_run_enable_i,
    input wire logic event_clock_select_i,
    input wire logic fast_clock_source_select_i,
    input wire logic [RATE_W-1:0] prescale_rate_select_i,
    input wire logic auto_load_select_i,
    input wire logic buzzer_output_enable_i,
    input wire logic pwm_output_enable_i,
    input wire logic overflow_interrupt_enable_i,
    input wire logic count_wr_i,
    input wire logic [CNT_W-1:0] count_wdata_i,
    input wire logic reload_wr_i,
    input wire logic [CNT_W-1:0] reload_wdata_i,
    input wire logic overflow_flag_clear_i,
    input wire logic event_input_pin_i,
    input wire logic event_pin_irq_clear_i,
    input wire logic gpio_out_i,
    input wire logic gpio_oe_i,
    output logic [CNT_W-1:0] timer_count_o,
    output logic overflow_request_flag_o,
    output logic irq_o,
    output logic overflow_pulse_o,
    output logic event_pin_irq_flag_o,
    output logic event_pin_wake_o,
    output logic buzzer_pwm_pin_o,
    output logic buzzer_pwm_pin_oe_o
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (COUNT_WIDTH != CNT_W) begin : g_width_check
        $error("timer counter width must be 8");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] shadow;
        logic [CNT_W-1:0] active;
        logic ovf_flag;
        logic irq;
        logic ovf_pulse;
        logic buzz;
        logic pwm;
        logic pin;
        logic pin_oe;
        logic pin_irq;
        logic wake;
    } timer_state_t;

    timer_state_t st_ff;
    timer_state_t nxt_st;

    localparam timer_state_t STATE_RST = '{
        cnt: CNT_RST,
        shadow: RELOAD_RST,
        active: RELOAD_RST,
        ovf_flag: 1'b0,
        irq: 1'b0,
        ovf_pulse: 1'b0,
        buzz: 1'b0,
        pwm: 1'b1,
        pin: 1'b0,
        pin_oe: 1'b0,
        pin_irq: 1'b0,
        wake: 1'b0
    };

    // ------------------------------------------------------------------
    // count clock sources
    // ------------------------------------------------------------------
    logic event_fall;
    logic pre_tick;
    logic count_tick;
    logic pwm_mode;
    logic [CNT_W-1:0] mask;
    logic ovf;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] duty_next;

    event_front u_event_front (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .pin_i(event_input_pin_i),
        .fall_o(event_fall)
    );

    // prescaler idles while the event clock is selected
    rate_prescaler u_rate_prescaler (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .run_i(timer_run_enable_i & ~event_clock_select_i), // [R20]
        .fast_i(fast_clock_source_select_i),
        .cpu_tick_i(cpu_tick_i),
        .rate_i(prescale_rate_select_i),
        .tick_o(pre_tick)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        pwm_mode = pwm_output_enable_i & ~event_clock_select_i;

        // event edges replace the prescaled tick when selected
        count_tick = timer_run_enable_i &
            (event_clock_select_i ? event_fall : pre_tick); // [R1] [R2]

        // event mode always overflows at the full 256-count boundary (mask ff)
        mask = boundary_mask(pwm_mode, auto_load_select_i,
                             buzzer_output_enable_i); // [R15]
        ovf = count_tick & ((st_ff.cnt & mask) == mask); // [R3] [R16]
        cnt_inc = st_ff.cnt + CNT_ONE;

        // counter: software write wins over a count in the same cycle
        cnt_next = st_ff.cnt;
        if (ovf) begin
            if (pwm_mode) begin
                cnt_next = CNT_ZERO; // [R12]
            end else begin
                cnt_next = st_ff.shadow; // [R21]
            end
        end else if (count_tick) begin
            cnt_next = cnt_inc; // [R2]
        end
        if (count_wr_i) begin
            cnt_next = count_wdata_i;
        end
        nxt_st.cnt = cnt_next;

        // shadow holds software writes until the next overflow
        if (reload_wr_i) begin
            nxt_st.shadow = reload_wdata_i; // [R22]
        end
        if (ovf) begin
            nxt_st.active = st_ff.shadow; // [R22] [R14]
        end
        duty_next = ovf ? st_ff.shadow : st_ff.active;

        // overflow flag: a set in the clearing cycle wins
        if (ovf) begin
            nxt_st.ovf_flag = 1'b1; // [R8]
        end else if (overflow_flag_clear_i) begin
            nxt_st.ovf_flag = 1'b0;
        end
        nxt_st.irq = nxt_st.ovf_flag & overflow_interrupt_enable_i; // [R8]
        nxt_st.ovf_pulse = ovf; // [R3]

        // buzzer square wave keeps running even while the pin is gpio
        if (ovf) begin
            nxt_st.buzz = ~st_ff.buzz; // [R6] [R18]
        end

        // pwm level: equality with the duty forces low, overflow restarts high
        if (!timer_run_enable_i || !pwm_mode) begin
            nxt_st.pwm = 1'b1;
        end else if ((cnt_next & mask) == (duty_next & mask)) begin
            nxt_st.pwm = 1'b0; // [R11]
        end else if (ovf) begin
            nxt_st.pwm = 1'b1; // [R12] [R11]
        end

        // shared pin mux; gpio settings pass through untouched when released
        if (pwm_output_enable_i && timer_run_enable_i) begin
            nxt_st.pin = nxt_st.pwm; // [R10] [R17]
            nxt_st.pin_oe = 1'b1;
        end else if (buzzer_output_enable_i && !pwm_output_enable_i) begin
            nxt_st.pin = nxt_st.buzz; // [R7] [R9]
            nxt_st.pin_oe = 1'b1;
        end else begin
            nxt_st.pin = gpio_out_i; // [R7] [R17] [R18]
            nxt_st.pin_oe = gpio_oe_i;
        end

        // event pin as gpio interrupt and wake source, muted when counting
        if (event_clock_select_i) begin
            nxt_st.pin_irq = 1'b0; // [R5]
            nxt_st.wake = 1'b0; // [R4]
        end else begin
            if (event_fall) begin
                nxt_st.pin_irq = 1'b1;
            end else if (event_pin_irq_clear_i) begin
                nxt_st.pin_irq = 1'b0;
            end
            nxt_st.wake = event_fall; // [R4]
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_ff <= STATE_RST;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all taken from flip-flops
    // ------------------------------------------------------------------
    assign timer_count_o = st_ff.cnt;
    assign overflow_request_flag_o = st_ff.ovf_flag;
    assign irq_o = st_ff.irq;
    assign overflow_pulse_o = st_ff.ovf_pulse;
    assign event_pin_irq_flag_o = st_ff.pin_irq;
    assign event_pin_wake_o = st_ff.wake;
    assign buzzer_pwm_pin_o = st_ff.pin;
    assign buzzer_pwm_pin_oe_o = st_ff.pin_oe;

endmodule

`default_nettype wire

// *** dv/pulse_source.sv ***
/* Far-side pulse source for the timer's event input pin.
   Assumes nothing of the bench clock: edges run on their own 37.5 ns beat. */
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input wire logic en_i,
    output var logic pin_o,
    output var int falls_o
);
    initial begin
        pin_o = 1'b1;
        falls_o = 0;
    end
    // returns to the idle high level once disabled, so no stray fall
    always begin
        #37.5;
        if (en_i || !pin_o) begin
            pin_o = ~pin_o;
            falls_o = falls_o + (pin_o ? 0 : 1);
        end
    end
endmodule
`default_nettype wire

// *** dv/timer_pwm_sva.sv ***
/* Port checker for the timer, bound to its top module.
   Assumes one clock domain; cycles with ce_i low are excluded. */
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_sva
    import tmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic timer_run_enable_i,
    input wire logic event_clock_select_i,
    input wire logic buzzer_output_enable_i,
    input wire logic pwm_output_enable_i,
    input wire logic overflow_interrupt_enable_i,
    input wire logic count_wr_i,
    input wire logic gpio_out_i,
    input wire logic gpio_oe_i,
    input wire logic [CNT_W-1:0] timer_count_o,
    input wire logic overflow_request_flag_o,
    input wire logic irq_o,
    input wire logic overflow_pulse_o,
    input wire logic event_pin_irq_flag_o,
    input wire logic event_pin_wake_o,
    input wire logic buzzer_pwm_pin_o,
    input wire logic buzzer_pwm_pin_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic bz;
    assign bz = buzzer_output_enable_i && !pwm_output_enable_i;
    // --------------------------------
    // assertions
    // --------------------------------
    chk_evt_flag_zero: assert property (
        ce_i && event_clock_select_i |=> !event_pin_irq_flag_o)
        else $error("event pin flag set");
    chk_wake_muted: assert property (
        ce_i && event_clock_select_i |=> !event_pin_wake_o)
        else $error("wake while counting");
    chk_irq_follows: assert property (
        $past(ce_i) |-> irq_o == (overflow_request_flag_o && $past(overflow_interrupt_enable_i)))
        else $error("irq mismatch");
    chk_ovf_sets_flag: assert property (
        overflow_pulse_o |-> overflow_request_flag_o)
        else $error("flag not set");
    chk_wrap_from_ff: assert property (
        overflow_pulse_o && !$past(pwm_output_enable_i) && !$past(count_wr_i)
        && $past(ce_i) |-> $past(timer_count_o) == 8'hff)
        else $error("wrap not from ff");
    chk_buzz_on_ovf: assert property (
        $past(bz) && $past(bz, 2) && $changed(buzzer_pwm_pin_o)
        |-> overflow_pulse_o || $past(overflow_pulse_o))
        else $error("buzzer moved off overflow");
    chk_pin_gpio: assert property (
        $past(rst_b_i) && $past(ce_i)
        && !$past(buzzer_output_enable_i) && !$past(pwm_output_enable_i)
        |-> {buzzer_pwm_pin_oe_o, buzzer_pwm_pin_o} == $past({gpio_oe_i, gpio_out_i}))
        else $error("pin not gpio");
    chk_pin_driven: assert property (
        $past(rst_b_i) && $past(bz || timer_run_enable_i && pwm_output_enable_i)
        && $past(ce_i) |-> buzzer_pwm_pin_oe_o)
        else $error("pin not driven");
    chk_event_step: assert property (
        $past(rst_b_i) && $past(timer_run_enable_i && event_clock_select_i && !count_wr_i)
        && !overflow_pulse_o |-> timer_count_o == $past(timer_count_o)
        || timer_count_o == $past(timer_count_o) + 8'h01)
        else $error("event step not one");
    cov_pwm_ovf: cover property (overflow_pulse_o && pwm_output_enable_i);
    cov_buzz_ovf: cover property (overflow_pulse_o && bz);
    cov_evt_ovf: cover property (overflow_pulse_o && event_clock_select_i);
endmodule
bind timer_event_counter_buzzer_pwm timer_pwm_sva timer_pwm_sva_i (
    .clk_i, .rst_b_i, .ce_i, .timer_run_enable_i, .event_clock_select_i,
    .buzzer_output_enable_i, .pwm_output_enable_i, .overflow_interrupt_enable_i,
    .count_wr_i, .gpio_out_i, .gpio_oe_i, .timer_count_o, .overflow_request_flag_o,
    .irq_o, .overflow_pulse_o, .event_pin_irq_flag_o, .event_pin_wake_o,
    .buzzer_pwm_pin_o, .buzzer_pwm_pin_oe_o);
`default_nettype wire

// *** dv/tb_timer_event_counter_buzzer_pwm.sv ***
/* Self-checking bench: timer, buzzer, pwm and event counting runs.
   Assumes tmr_pkg, the design, pulse_source and the checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module tb_timer_event_counter_buzzer_pwm;
    import tmr_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, tick = 1'b0, run = 1'b0, evt = 1'b0;
    logic fast = 1'b0, aload = 1'b0, buzz = 1'b0, pwm = 1'b0, ien = 1'b0, en = 1'b0;
    logic cwr = 1'b0, rwr = 1'b0, fclr = 1'b0, eclr = 1'b0, goe = 1'b0, gout = 1'b0, ce = 1'b1;
    logic [RATE_W-1:0] rate = 3'h0;
    logic [CNT_W-1:0] cdat = 8'h00, rdat = 8'h00, cnt;
    logic flag, irq, ovf, eflag, wake, pin, oe, epin;
    logic [16:0] seed = 17'h17a0d;
    int n_fail = 0, n_checks = 0, falls, n_wake = 0;
    always #5 clk_i = ~clk_i;
    // slow cpu strobe on every other cycle
    always @(posedge clk_i) #1 tick = ~tick;
    timer_event_counter_buzzer_pwm timer_event_counter_buzzer_pwm_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .cpu_tick_i(tick),
        .timer_run_enable_i(run), .event_clock_select_i(evt),
        .fast_clock_source_select_i(fast), .prescale_rate_select_i(rate),
        .auto_load_select_i(aload), .buzzer_output_enable_i(buzz),
        .pwm_output_enable_i(pwm), .overflow_interrupt_enable_i(ien),
        .count_wr_i(cwr), .count_wdata_i(cdat), .reload_wr_i(rwr), .reload_wdata_i(rdat),
        .overflow_flag_clear_i(fclr), .event_input_pin_i(epin),
        .event_pin_irq_clear_i(eclr), .gpio_out_i(gout), .gpio_oe_i(goe),
        .timer_count_o(cnt), .overflow_request_flag_o(flag), .irq_o(irq),
        .overflow_pulse_o(ovf), .event_pin_irq_flag_o(eflag), .event_pin_wake_o(wake),
        .buzzer_pwm_pin_o(pin), .buzzer_pwm_pin_oe_o(oe));
    pulse_source pulse_source_i (.en_i(en), .pin_o(epin), .falls_o(falls));
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_v(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_n(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) begin
            @(posedge clk_i);
            #1;
            seed = lfsr(seed);
            {goe, gout} = seed[1:0];
            n_wake += int'(wake === 1'b1);
        end
    endtask
    task automatic load(input logic [7:0] c, input logic [7:0] r);
        {cdat, rdat} = {c, r};
        {cwr, rwr, fclr} = 3'h7;
        step();
        {cwr, rwr, fclr, eclr} = 4'h0;
    endtask
    // cycles and high cycles from one overflow to the next; wr loads a reload
    task automatic measure(input logic [8:0] wr, output int per, output int hi);
        int k;
        per = 0;
        hi = 0;
        k = 0;
        if (wr[8]) {rwr, rdat} = wr;
        while (ovf !== 1'b1 && k < 2000) begin
            step();
            k++;
        end
        // the overflow edge opens the period, so its level belongs to it
        do begin
            hi += int'(pin === 1'b1);
            step();
            if (per == 0 && wr[8]) rwr = 1'b0;
            per++;
            k++;
        end while (ovf !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        int per, hi, f0;
        logic [7:0] r, d, d2, m;
        step(12);
        rst_b_i = 1'b1;
        step(2);
        for (int i = 0; i < 2; i++) begin
            {fast, rate} = i ? 4'he : 4'h7;
            ien = i[0];
            r = 8'hf0 | seed[7:0];
            load(r, r);
            run = 1'b1;
            measure(9'h000, per, hi);
            cmp_n("interval", (256 - r) * (4 >> i), per);
            cmp_v("reload", r, cnt);
            cmp_v("ovf_flag", 8'h01, flag);
            cmp_v("irq", {7'h00, i[0]}, irq);
            run = 1'b0;
            step();
        end
        {fast, rate} = 4'hf;
        r = 8'hf0 | seed[2:0];
        load(r, r);
        buzz = 1'b1;
        run = 1'b1;
        measure(9'h000, per, hi);
        measure(9'h000, per, f0);
        cmp_n("buzz_period", 256 - r, per);
        cmp_n("buzz_high", per, hi + f0);
        cmp_v("buzz_oe", 8'h01, oe);
        buzz = 1'b0;
        r = cnt;
        step(3);
        cmp_n("runs_on", 1, int'(cnt !== r));
        r = cnt;
        ce = 1'b0;
        step(4);
        cmp_v("ce_hold", r, cnt);
        ce = 1'b1;
        for (int j = 0; j < 4; j++) begin
            {aload, buzz} = j[1:0];
            m = (j == 0) ? 8'hff : 8'h3f >> (j - 1);
            d = (j == 1) ? m : seed[7:0] & m;
            d2 = (j == 3) ? 8'h00 : seed[15:8] & m;
            load(8'h00, d);
            pwm = 1'b1;
            measure(9'h000, per, hi);
            cmp_n("pwm_period", m + 1, per);
            cmp_n("pwm_high", d, hi);
            measure({1'b1, d2}, per, hi);
            cmp_n("pwm_hold", d, hi);
            measure(9'h000, per, hi);
            cmp_n("pwm_next", d2, hi);
            cmp_v("pwm_oe", 8'h01, oe);
            pwm = 1'b0;
            step();
        end
        {run, buzz, en} = 3'h1;
        step(40);
        en = 1'b0;
        step(20);
        cmp_v("pin_flag", 8'h01, eflag);
        cmp_n("wakes", falls, n_wake);
        eclr = 1'b1;
        {fast, rate} = seed[3:0];
        load(8'hf8, 8'hf8);
        {evt, run} = 2'h3;
        f0 = falls;
        en = 1'b1;
        step(300);
        en = 1'b0;
        step(20);
        cmp_v("events", 8'(8'hf8 + (falls - f0) % 8), cnt);
        cmp_v("evt_ovf_flag", 8'h01, flag);
        cmp_v("pin_flag", 8'h00, eflag);
        cmp_n("wake_muted", f0, n_wake);
        give_verdict();
    end
endmodule
`default_nettype wire
